// file: verif/card_model.sv
// Purpose: Card at the far end of the RF link
// Assumes: One received bit per cycle of valid
// Notes: Idle bit line toggles so stale data never looks valid
`timescale 1ns/100ps
module card_model
  import crc_frame_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clr,
  input wire logic txBit,
  input wire logic txBitValid,
  input wire logic sendGo,
  input wire logic [31:0] sendVec,
  input wire logic [5:0] sendLen,
  output rxIn_t rxIn = '0,
  output logic [31:0] got,
  output logic [5:0] gotN = 6'h00,
  output logic busy = 1'b0
);
  logic [5:0] idx = 6'h00;
  rxIn_t nx;
  always @(posedge ref_clk) begin
    if (clr) gotN <= 6'h00;
    else if (txBitValid) begin
      got[gotN[4:0]] <= txBit;
      gotN <= gotN + 6'h01;
    end
    // Bundle is assigned once per edge; bit line toggles while idle
    nx = '{bit_: ~rxIn.bit_, default: 1'b0};
    if (sendGo && !busy) begin
      busy <= 1'b1;
      idx <= 6'h00;
      nx.start = 1'b1;
    end else if (busy && idx == sendLen) begin
      busy <= 1'b0;
      nx.end_ = 1'b1;
    end else if (busy) begin
      nx.valid = 1'b1;
      nx.bit_ = sendVec[idx[4:0]];
      idx <= idx + 6'h01;
    end
    rxIn <= nx;
  end
endmodule : card_model

// file: verif/crc_frame_monitor.sv
// Purpose: Port checker for crc_frame_ctrl
// Assumes: One clock, rst synchronous
// Notes: Bit spacing uses ETU_CYCLES
`timescale 1ns/100ps
module crc_frame_monitor
  import crc_frame_pkg::*;
#(parameter int ETU_CYCLES = 4) (
  input wire logic ref_clk,
  input wire logic rst,
  input regReq_t busReq,
  input wire logic [7:0] busRdata,
  input wire logic txReady,
  input wire logic txBitValid,
  input wire logic txSymbol,
  input wire logic txBusy,
  input wire logic rxByteValid,
  input wire logic [3:0] overshootPhaseOneLen,
  input wire logic [3:0] loadCurrentTrim
);
  logic [15:0] gap;
  logic seen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_trim_wr;
    busReq.we && busReq.addr == 8'h2B;
  endsequence
  sequence s_rd(logic [7:0] a);
    busReq.re && busReq.addr == a;
  endsequence
  // Gap saturates so a long idle never wraps into a false short gap
  always_ff @(posedge ref_clk) begin
    if (rst || txBitValid) gap <= 16'h0000;
    else if (gap != 16'hFFFF) gap <= gap + 16'h0001;
    // Spacing is judged within one frame; a free start may come sooner
    seen <= !rst && txBusy && (seen || txBitValid);
  end
  a_trim_low_load: assert property (
    s_trim_wr |=> loadCurrentTrim == $past(busReq.wdata[3:0]))
    else $error("trim not loaded");
  a_overshoot_load: assert property (
    s_trim_wr |=> overshootPhaseOneLen == $past(busReq.wdata[7:4]))
    else $error("overshoot not loaded");
  a_trim_holds: assert property (
    !(busReq.we && busReq.addr == 8'h2B) |=> $stable(loadCurrentTrim))
    else $error("trim changed");
  a_txcfg_reserved: assert property (
    s_rd(8'h2C) |=> busRdata[7] == 1'b0)
    else $error("tx check bit 7 set");
  a_frame_reserved: assert property (
    s_rd(8'h2E) |=> busRdata[7:5] == 3'h0)
    else $error("frame bits 7:5 set");
  a_bit_spacing: assert property (
    txBitValid && seen |-> gap >= ETU_CYCLES - 1)
    else $error("bits closer than one ETU");
  a_symbol_no_data: assert property (
    txSymbol |-> !txReady && !txBitValid)
    else $error("data during symbol");
  a_byte_pulse: assert property (
    rxByteValid |=> !rxByteValid)
    else $error("byte strobe too long");
endmodule : crc_frame_monitor
bind crc_frame_ctrl crc_frame_monitor #(.ETU_CYCLES(ETU_CYCLES)) u_mon (
  .ref_clk(ref_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
  .txReady(txReady), .txBitValid(txBitValid), .txSymbol(txSymbol),
  .txBusy(txBusy),
  .rxByteValid(rxByteValid), .overshootPhaseOneLen(overshootPhaseOneLen),
  .loadCurrentTrim(loadCurrentTrim));

// file: verif/tb_top.sv
// Purpose: Self-checking bench for crc_frame_ctrl
// Assumes: ETU shortened to 4 cycles
// Notes: Card model answers with 16-bit frames, 13 bits for the CRC5 case
`timescale 1ns/100ps
`include "crc_frame_map.svh"
module tb_top;
  import crc_frame_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  regReq_t busReq = '0;
  logic [7:0] busRdata, rxByte, v, txData = 8'h00;
  logic txGo = 1'b0, txValid = 1'b0, txLast = 1'b0, clr = 1'b0;
  logic irq, txReady, txBit, txBitValid, txSymbol, txBusy, rxByteValid;
  logic [2:0] rxPartBits;
  logic [3:0] ovr, trim;
  rxIn_t rxIn;
  logic sendGo = 1'b0, cardBusy;
  logic [31:0] sendVec = 32'h0, got;
  logic [5:0] sendLen = 6'h10;
  logic [5:0] gotN;
  logic [15:0] c8, c5;
  logic [7:0] rxQ[$];
  int errors = 0, samplesChecked = 0, cyc = 0;
  crc_frame_ctrl #(.ETU_CYCLES(4)) dut (
    .ref_clk(ref_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .irq(irq), .txGo(txGo), .txData(txData), .txValid(txValid),
    .txLast(txLast), .txReady(txReady), .txBit(txBit),
    .txBitValid(txBitValid), .txSymbol(txSymbol), .txBusy(txBusy),
    .rxIn(rxIn), .rxByte(rxByte), .rxByteValid(rxByteValid),
    .rxPartBits(rxPartBits), .userPreset16(16'h1234),
    .userPreset8(8'h5C), .userPreset5(5'h0B),
    .overshootPhaseOneLen(ovr), .loadCurrentTrim(trim));
  card_model card (
    .ref_clk(ref_clk), .clr(clr), .txBit(txBit), .txBitValid(txBitValid),
    .sendGo(sendGo), .sendVec(sendVec), .sendLen(sendLen), .rxIn(rxIn),
    .got(got), .gotN(gotN), .busy(cardBusy));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (rxByteValid === 1'b1) rxQ.push_back(rxByte);
    if (cyc == 20000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] crc(logic [15:0] c, logic [15:0] p,
      logic [7:0] d, int n);
    for (int i = 0; i < n; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ p) : (c >> 1);
    end
    return c;
  endfunction : crc
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk);
    busReq.we <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk);
    busReq.re <= 1'b0;
    @(negedge ref_clk);
    d = busRdata;
  endtask : rd
  task automatic reg_case();
    logic [23:0] t[5] = '{24'h10FF00, 24'h2CFF7F, 24'h2EFF1F,
      24'h2DFFFF, 24'h2BA5A5};
    for (int a = 8'h2B; a <= 8'h39; a += (a == 8'h2E) ? 10 : 1) begin
      rd(a[7:0], v);
      chk("reset", v, `RST_REG);
    end
    foreach (t[i]) begin
      wr(t[i][23:16], t[i][15:8]);
      rd(t[i][23:16], v);
      chk("readback", v, t[i][7:0]);
    end
    chk("load trim", trim, 4'h5);
    chk("overshoot", ovr, 4'hA);
  endtask : reg_case
  task automatic go();
    @(posedge ref_clk);
    clr <= 1'b1;
    txGo <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    txGo <= 1'b0;
  endtask : go
  task automatic tx_case(logic [7:0] cfg, logic [7:0] frm, logic [7:0] d,
      logic [15:0] init);
    logic [15:0] c;
    logic [31:0] e;
    int n, w, k;
    k = cfg[3:2];
    n = (frm[2:0] == 3'h0) ? 8 : frm[2:0];
    w = (k == 0) ? 5 : (k == 1) ? 8 : (k == 2) ? 16 : 0;
    if (!cfg[0]) w = 0;
    c = crc(init, (k == 0) ? `POLY5 : (k == 1) ? `POLY8 : `POLY16, d, n);
    if (cfg[1]) c = ~c;
    e = ({24'h0, d} & ((32'h1 << n) - 1))
      | (({16'h0, c} & ((32'h1 << w) - 1)) << n);
    wr(`OFS_TX_CHECK, cfg);
    wr(`OFS_TX_FRAME, frm);
    go();
    txData <= d;
    txValid <= 1'b1;
    txLast <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge ref_clk);
      if (txReady === 1'b1) break;
    end
    txValid <= 1'b0;
    for (k = 0; k < 500; k++) begin
      @(negedge ref_clk);
      if (txBusy === 1'b0) break;
    end
    // The last bit reaches the card one edge after busy drops
    @(negedge ref_clk);
    chk("tx count", gotN, n + w);
    chk("tx bits", got & ((32'h1 << (n + w)) - 1), e);
  endtask : tx_case
  task automatic sym_case();
    logic seen = 1'b0;
    wr(`OFS_TX_FRAME, 8'h00);
    go();
    for (int k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      seen |= (txSymbol === 1'b1);
      if (txBusy === 1'b0) break;
    end
    chk("symbol", seen, 1'b1);
    chk("symbol bits", gotN, 6'h00);
  endtask : sym_case
  task automatic rx_case(logic [7:0] cfg, logic [7:0] ck, logic err, int nb,
      int len, logic [2:0] part);
    wr(`OFS_RX_CHECK, cfg);
    wr(`OFS_IRQ_STATUS, 8'h07);
    rxQ.delete();
    @(posedge ref_clk);
    sendVec <= {16'h0, ck, 8'h5A};
    sendLen <= len[5:0];
    sendGo <= 1'b1;
    @(posedge ref_clk);
    sendGo <= 1'b0;
    for (int k = 0; k < 100; k++) begin
      @(negedge ref_clk);
      if (cardBusy === 1'b0) break;
    end
    rd(`OFS_IRQ_STATUS, v);
    chk("crc error", v[2], err);
    chk("rx done", v[1], 1'b1);
    chk("rx bytes", rxQ.size(), nb);
    chk("rx last", rxQ.size() > 0 ? rxQ[$] : 8'h00,
      (nb == 2) ? ck : 8'h5A);
    chk("rx part", rxPartBits, part);
  endtask : rx_case
  task automatic irq_case();
    wr(`OFS_IRQ_STATUS, 8'h07);
    tx_case(8'h00, 8'h08, 8'hC3, 16'h0000);
    chk("masked irq", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 8'h01);
    @(negedge ref_clk);
    chk("irq set", irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 8'h01);
    @(negedge ref_clk);
    chk("irq clear", irq, 1'b0);
  endtask : irq_case
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    reg_case();
    c8 = crc(16'h00FF, `POLY8, 8'h5A, 8);
    c5 = crc(16'h001F, `POLY5, 8'h5A, 8);
    irq_case();
    tx_case(8'h75, 8'h0B, 8'hB2, 16'h00FF);
    tx_case(8'h1B, 8'h08, 8'h96, 16'h6363);
    tx_case(8'h29, 8'h18, 8'h0F, 16'hA671);
    tx_case(8'h39, 8'h08, 8'h01, 16'hFFFE);
    tx_case(8'h71, 8'h1E, 8'h3C, 16'h001F);
    tx_case(8'h6B, 8'h08, 8'h5A, 16'h1234);
    tx_case(8'h49, 8'h08, 8'hA5, 16'h0000);
    tx_case(8'h0D, 8'h08, 8'h3C, 16'h0000);
    sym_case();
    rx_case(8'hF5, c8[7:0], 1'b0, 2, 16, 3'h0);
    rx_case(8'hF5, ~c8[7:0], 1'b1, 2, 16, 3'h0);
    rx_case(8'hF4, ~c8[7:0], 1'b0, 2, 16, 3'h0);
    rx_case(8'hF7, ~c8[7:0], 1'b0, 2, 16, 3'h0);
    rx_case(8'h75, c8[7:0], 1'b0, 1, 16, 3'h0);
    rx_case(8'hF1, {3'h0, c5[4:0]}, 1'b0, 2, 13, 3'h5);
    end_of_test();
  end
endmodule : tb_top

// file: verilog/crc_frame_ctrl.sv
// Purpose: CRC generation/check and transmit framing with register port
// Assumes: Inputs synchronous to ref_clk; one RF bit per ETU
// Notes: Registers at 0x2B..0x2E, interrupt status/mask at 0x38/0x39
`timescale 1ns/100ps
`include "crc_frame_map.svh"
module crc_frame_ctrl
  import crc_frame_pkg::*;
#(
  parameter int ETU_CYCLES = `ETU_NS * `CLK_MHZ / 1000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input regReq_t busReq,
  output logic [7:0] busRdata,
  output logic irq,
  input wire logic txGo,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txLast,
  output logic txReady,
  output logic txBit,
  output logic txBitValid,
  output logic txSymbol,
  output logic txBusy,
  input rxIn_t rxIn,
  output logic [7:0] rxByte,
  output logic rxByteValid,
  output logic [2:0] rxPartBits,
  input wire logic [15:0] userPreset16,
  input wire logic [7:0] userPreset8,
  input wire logic [4:0] userPreset5,
  output logic [3:0] overshootPhaseOneLen,
  output logic [3:0] loadCurrentTrim
);

  // The grid counter is 16 bits wide and must reload to at least 1
  if (ETU_CYCLES < 2 || ETU_CYCLES > 65535) begin : g_etu_range
    $error("ETU_CYCLES out of range");
  end

  localparam logic [15:0] ETU_RELOAD = 16'(ETU_CYCLES - 1);

  blkState_t s;
  blkState_t next_s;

  // Width 0 marks the reserved kind: nothing appended or checked
  function automatic logic [4:0] kindWidth(input chkKind_t k);
    case (k)
      CK_CRC5: kindWidth = 5'd5;
      CK_CRC8: kindWidth = 5'd8;
      CK_CRC16: kindWidth = 5'd16;
      default: kindWidth = 5'd0;
    endcase
  endfunction : kindWidth

  // One LSB-first shift of a reflected CRC held in the low bits
  function automatic logic [15:0] crcStep(input logic [15:0] c,
      input logic b, input chkKind_t k);
    logic [15:0] r;
    r = {1'b0, c[15:1]};
    if (c[0] ^ b) begin
      case (k)
        CK_CRC5: r = r ^ `POLY5;
        CK_CRC8: r = r ^ `POLY8;
        default: r = r ^ `POLY16;
      endcase
    end
    crcStep = r;
  endfunction : crcStep

  // Code 6 reads static preset inputs; their storage lies outside
  // Undefined codes start from zero
  function automatic logic [15:0] initVal(input chkKind_t k,
      input logic [2:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    case (k)
      CK_CRC16: begin
        case (sel)
          3'h1: v = 16'h6363;
          3'h2: v = 16'hA671;
          3'h3: v = 16'hFFFE;
          3'h6: v = userPreset16;
          3'h7: v = 16'hFFFF;
          default: v = 16'h0000;
        endcase
      end
      CK_CRC8: begin
        case (sel)
          3'h1: v = 16'h0012;
          3'h2: v = 16'h00BF;
          3'h3: v = 16'h00FD;
          3'h6: v = {8'h00, userPreset8};
          3'h7: v = 16'h00FF;
          default: v = 16'h0000;
        endcase
      end
      CK_CRC5: begin
        case (sel)
          3'h1: v = 16'h0012;
          3'h6: v = {11'h000, userPreset5};
          3'h7: v = 16'h001F;
          default: v = 16'h0000;
        endcase
      end
      default: v = 16'h0000;
    endcase
    initVal = v;
  endfunction : initVal

  function automatic logic [15:0] widthMask(input logic [4:0] w);
    widthMask = 16'((32'h1 << w) - 1);
  endfunction : widthMask

  function automatic logic [15:0] bitRev(input logic [15:0] v);
    for (int i = 0; i < 16; i++) begin
      bitRev[i] = v[15 - i];
    end
  endfunction : bitRev

  chkKind_t txKind;
  chkKind_t rxKind;
  logic [4:0] txW;
  logic [4:0] rxW;
  logic etuTick;
  logic rxOld;
  logic rxByteBit;
  logic rxByteBitOk;
  logic [15:0] rxRecv;
  logic [15:0] rxExp;
  logic [15:0] txOut;

  assign txKind = chkKind_t'(s.txCfg[`CHK_KIND_LO +: 2]);
  assign rxKind = chkKind_t'(s.rxCfg[`CHK_KIND_LO +: 2]);
  assign txW = kindWidth(txKind);
  assign rxW = kindWidth(rxKind);
  assign etuTick = (s.etu == 16'h0000);
  // Ready is combinational so a byte offered now is taken at this edge
  assign txReady = (s.st == ST_DATA) && s.needByte;
  assign rxOld = s.rxSh[4'(rxW - 5'd1)];
  // Received CRC arrives LSB first, so the oldest held bit is bit 0
  assign rxRecv = bitRev(s.rxSh) >> (5'd16 - rxW);
  assign rxExp = (s.rxCrc ^ (s.rxCfg[`CHK_INV] ? 16'hFFFF : 16'h0000))
      & widthMask(rxW);
  // Complement only touches what goes on air; the running value stays plain
  assign txOut = s.txCrc ^ (s.txCfg[`CHK_INV] ? 16'hFFFF : 16'h0000);

  // With to-FIFO off, bytes come from the delayed stream so the last
  // W bits (the CRC) never reach the byte output
  always_comb begin
    if (s.rxCfg[`RX_TO_FIFO]) begin
      rxByteBit = rxIn.bit_;
      rxByteBitOk = 1'b1;
    end else if (rxW == 5'd0) begin
      // Reserved kind has no trailer, so nothing is withheld
      rxByteBit = rxIn.bit_;
      rxByteBitOk = 1'b1;
    end else begin
      rxByteBit = rxOld;
      rxByteBitOk = (s.rxCnt >= rxW);
    end
  end

  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    next_s.txBitValid = 1'b0;
    next_s.rxByteValid = 1'b0;

    // Register port
    // Unmapped writes fall through and change nothing
    if (busReq.we) begin
      if (busReq.addr == `OFS_TX_TRIM) begin
        next_s.trim = busReq.wdata;
      end else if (busReq.addr == `OFS_TX_CHECK) begin
        next_s.txCfg = busReq.wdata[6:0];
      end else if (busReq.addr == `OFS_RX_CHECK) begin
        next_s.rxCfg = busReq.wdata;
      end else if (busReq.addr == `OFS_TX_FRAME) begin
        next_s.frm = busReq.wdata[4:0];
      end else if (busReq.addr == `OFS_IRQ_STATUS) begin
        next_s.irqSt = s.irqSt & ~busReq.wdata[2:0];
      end else if (busReq.addr == `OFS_IRQ_MASK) begin
        next_s.irqMsk = busReq.wdata[2:0];
      end
    end
    // Read data stands one cycle, then returns to zero
    if (busReq.re) begin
      if (busReq.addr == `OFS_TX_TRIM) begin
        next_s.rdata = s.trim;
      end else if (busReq.addr == `OFS_TX_CHECK) begin
        next_s.rdata = {1'b0, s.txCfg};
      end else if (busReq.addr == `OFS_RX_CHECK) begin
        next_s.rdata = s.rxCfg;
      end else if (busReq.addr == `OFS_TX_FRAME) begin
        next_s.rdata = {3'b000, s.frm};
      end else if (busReq.addr == `OFS_IRQ_STATUS) begin
        next_s.rdata = {5'b00000, s.irqSt};
      end else if (busReq.addr == `OFS_IRQ_MASK) begin
        next_s.rdata = {5'b00000, s.irqMsk};
      end else begin
        next_s.rdata = 8'h00;
      end
    end

    // Free-running ETU grid; a free start restarts it
    next_s.etu = etuTick ? ETU_RELOAD : s.etu - 16'h0001;

    // Transmit
    case (s.st)
      ST_IDLE: begin
        // Only idle looks at txGo, so a start while busy is lost
        if (txGo) begin
          next_s.txCrc = initVal(txKind, s.txCfg[`CHK_SEL_LO +: 3]);
          if (!s.frm[`FRM_GRID]) begin
            next_s.etu = ETU_RELOAD;
          end
          next_s.txCnt = 5'd0;
          next_s.needByte = 1'b1;
          next_s.st = s.frm[`FRM_PAYLOAD] ? ST_DATA : ST_SYMBOL;
        end
      end
      ST_DATA: begin
        if (s.needByte) begin
          // An empty source stalls here; no bits go out until a byte comes
          if (txValid) begin
            next_s.txSh = txData;
            next_s.txLastByte = txLast;
            next_s.txCnt = 5'd0;
            next_s.needByte = 1'b0;
            if (txLast && s.frm[`FRM_LAST_LO +: 3] != 3'b000) begin
              next_s.txLim = {1'b0, s.frm[`FRM_LAST_LO +: 3]};
            end else begin
              next_s.txLim = 4'd8;
            end
          end
        end else if (etuTick) begin
          // Bits go out on grid ticks only, so starts stay aligned
          next_s.txBit = s.txSh[0];
          next_s.txBitValid = 1'b1;
          next_s.txCrc = crcStep(s.txCrc, s.txSh[0], txKind);
          next_s.txSh = {1'b0, s.txSh[7:1]};
          next_s.txCnt = s.txCnt + 5'd1;
          if (s.txCnt + 5'd1 == {1'b0, s.txLim}) begin
            if (!s.txLastByte) begin
              next_s.needByte = 1'b1;
            end else if (s.txCfg[`CHK_EN] && txW != 5'd0) begin
              next_s.txCnt = 5'd0;
              next_s.st = ST_CHECK;
            end else begin
              next_s.st = ST_IDLE;
              next_s.irqSt[`IRQ_TX_DONE] = 1'b1;
            end
          end
        end
      end
      ST_CHECK: begin
        // Trailer goes out LSB first, one bit per grid tick
        if (etuTick) begin
          next_s.txBit = txOut[s.txCnt[3:0]];
          next_s.txBitValid = 1'b1;
          next_s.txCnt = s.txCnt + 5'd1;
          if (s.txCnt + 5'd1 == txW) begin
            next_s.st = ST_IDLE;
            next_s.irqSt[`IRQ_TX_DONE] = 1'b1;
          end
        end
      end
      default: begin
        // Symbol pattern: one ETU high, no payload and no CRC
        if (etuTick) begin
          if (!s.txSymbol) begin
            next_s.txSymbol = 1'b1;
          end else begin
            next_s.txSymbol = 1'b0;
            next_s.st = ST_IDLE;
            next_s.irqSt[`IRQ_TX_DONE] = 1'b1;
          end
        end
      end
    endcase

    // Receive
    // Start re-seeds the check; bits before a start fold into stale state
    if (rxIn.start) begin
      next_s.rxCrc = initVal(rxKind, s.rxCfg[`CHK_SEL_LO +: 3]);
      next_s.rxCnt = 5'd0;
      next_s.rxSh = 16'h0000;
      next_s.rxAsm = 8'h00;
      next_s.rxAsmCnt = 4'd0;
    end else if (rxIn.valid) begin
      next_s.rxSh = {s.rxSh[14:0], rxIn.bit_};
      if (s.rxCnt < 5'd16) begin
        next_s.rxCnt = s.rxCnt + 5'd1;
      end
      // CRC runs W bits behind so the trailer itself is never folded in
      if (s.rxCnt >= rxW && rxW != 5'd0) begin
        next_s.rxCrc = crcStep(s.rxCrc, rxOld, rxKind);
      end
      if (rxByteBitOk) begin
        next_s.rxAsm = {rxByteBit, s.rxAsm[7:1]};
        next_s.rxAsmCnt = s.rxAsmCnt + 4'd1;
        if (s.rxAsmCnt == 4'd7) begin
          next_s.rxByte = {rxByteBit, s.rxAsm[7:1]};
          next_s.rxByteValid = 1'b1;
          next_s.rxPartBits = 3'b000;
          next_s.rxAsmCnt = 4'd0;
        end
      end
    end else if (rxIn.end_) begin
      next_s.irqSt[`IRQ_RX_DONE] = 1'b1;
      if (s.rxCfg[`CHK_EN] && rxW != 5'd0) begin
        // A frame shorter than the CRC also counts as a mismatch
        if (s.rxCnt < rxW || rxRecv != rxExp) begin
          next_s.irqSt[`IRQ_CRC_ERR] = 1'b1;
        end
      end
      // Partial final byte is flushed right-aligned
      if (s.rxAsmCnt != 4'd0) begin
        next_s.rxByte = s.rxAsm >> (4'd8 - s.rxAsmCnt);
        next_s.rxByteValid = 1'b1;
        next_s.rxPartBits = s.rxAsmCnt[2:0];
        next_s.rxAsmCnt = 4'd0;
      end
    end

    // Events set after the clear above, so a same-cycle event wins
  end

  // Synchronous reset clears every field, so all outputs read zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.etu <= 16'h0000;
    end else begin
      s <= next_s;
    end
  end

  assign busRdata = s.rdata;
  // Level interrupt taken from registers, so it cannot glitch
  assign irq = |(s.irqSt & s.irqMsk);
  assign txBit = s.txBit;
  assign txBitValid = s.txBitValid;
  assign txSymbol = s.txSymbol;
  assign txBusy = (s.st != ST_IDLE);
  assign rxByte = s.rxByte;
  assign rxByteValid = s.rxByteValid;
  assign rxPartBits = s.rxPartBits;
  assign overshootPhaseOneLen = s.trim[7:4];
  assign loadCurrentTrim = s.trim[3:0];

endmodule : crc_frame_ctrl

// file: verilog/crc_frame_map.svh
// Purpose: Register map, field positions and timing for the CRC/framing block
// Assumes: Byte-wide register port, 250 MHz reference clock
// Notes: Register offsets are byte addresses
`ifndef CRC_FRAME_MAP_SVH
`define CRC_FRAME_MAP_SVH
`define OFS_TX_TRIM 8'h2B
`define OFS_TX_CHECK 8'h2C
`define OFS_RX_CHECK 8'h2D
`define OFS_TX_FRAME 8'h2E
`define OFS_IRQ_STATUS 8'h38
`define OFS_IRQ_MASK 8'h39
`define RST_REG 8'h00
// Field positions: CHK_* shared by both check registers, RX_TO_FIFO receive only, FRM_* in the frame register
`define CHK_EN 0
`define CHK_INV 1
`define CHK_KIND_LO 2
`define CHK_SEL_LO 4
`define RX_TO_FIFO 7
`define FRM_LAST_LO 0
`define FRM_PAYLOAD 3
`define FRM_GRID 4
// Interrupt status bits
`define IRQ_TX_DONE 0
`define IRQ_RX_DONE 1
`define IRQ_CRC_ERR 2
// Reflected polynomials, LSB-first shifting
`define POLY16 16'h8408
`define POLY8 16'h00B8
`define POLY5 16'h0012
`define CLK_MHZ 250
`define ETU_NS 9440
`endif

// file: verilog/crc_frame_pkg.sv
// Purpose: Types for the CRC/framing block
// Assumes: Constants come from crc_frame_map.svh
// Notes: All block state lives in blkState_t
package crc_frame_pkg;
  typedef enum logic [1:0] {CK_CRC5, CK_CRC8, CK_CRC16, CK_RFU} chkKind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_CHECK, ST_SYMBOL} txState_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } regReq_t;
  typedef struct packed {
    logic bit_;
    logic valid;
    logic end_;
    logic start;
  } rxIn_t;
  typedef struct packed {
    txState_t st;
    logic [7:0] trim;
    logic [6:0] txCfg;
    logic [7:0] rxCfg;
    logic [4:0] frm;
    logic [2:0] irqSt;
    logic [2:0] irqMsk;
    logic [7:0] rdata;
    logic [15:0] etu;
    logic [7:0] txSh;
    logic [4:0] txCnt;
    logic [3:0] txLim;
    logic txLastByte;
    logic needByte;
    logic [15:0] txCrc;
    logic txBit;
    logic txBitValid;
    logic txSymbol;
    logic [15:0] rxCrc;
    logic [15:0] rxSh;
    logic [4:0] rxCnt;
    logic [7:0] rxAsm;
    logic [3:0] rxAsmCnt;
    logic [7:0] rxByte;
    logic rxByteValid;
    logic [2:0] rxPartBits;
  } blkState_t;
endpackage : crc_frame_pkg
